// ==== core/host_serial_slave_port.sv ====
// Host serial slave port: select-framed serial link and two-wire slave path
`include "host_serial_slave_port_defs.svh"

module host_serial_slave_port
    import host_serial_slave_port_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic            reset_in,
    input  wire logic            host_shift_clock_in,
    input  wire logic            host_serial_in_in,
    output logic                 host_serial_in_out,
    output logic                 host_serial_in_oe_out,
    output logic                 host_serial_out_out,
    output logic                 host_serial_out_oe_out,
    input  wire logic            gpio_pin_zero_in,
    input  wire logic            host_select_in,
    output logic                 gpio_pin_one_out,
    output logic                 gpio_pin_one_oe_out,
    output logic                 busy_low_out,
    output logic                 busy_low_oe_out,
    input  wire logic            gpio_pin_two_in,
    input  wire logic            two_wire_mode_in,
    input  wire logic            tristate_mode_in,
    input  wire logic [5:0]      access_match_bits_in,
    input  wire logic            device_busy_in,
    input  wire logic [2:0]      gpio_out_in,
    input  wire logic [2:0]      gpio_oe_in,
    output logic [2:0]           gpio_read_out,
    input  wire logic [7:0]      tx_byte_in,
    output logic                 tx_taken_out,
    output host_byte_type        host_cmd_out,
    output link_status_type      link_status_out
);

    //==========================================================
    // Pin synchronisers and edge detection
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [2:0] prev;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            prev  <= 3'h0;
        end else begin
            sync1 <= {gpio_pin_two_in, gpio_pin_zero_in, host_select_in,
                      host_serial_in_in, host_shift_clock_in};
            sync2 <= sync1;
            prev  <= sync2[2:0];
        end
    end

    logic sck;
    logic sdi;
    logic sel;
    logic sck_rise;
    logic sck_fall;
    logic tw_start;
    logic tw_stop;

    assign sck      = sync2[0];
    assign sdi      = sync2[1];
    assign sel      = sync2[2];
    assign sck_rise = sck & ~prev[0];
    assign sck_fall = ~sck & prev[0];
    assign tw_start = sck & prev[0] & ~sdi & prev[1];
    assign tw_stop  = sck & prev[0] & sdi & ~prev[1];

    //==========================================================
    // Link state
    spi_state_type spi_state;
    spi_state_type next_spi_state;
    tw_state_type  tw_state;
    tw_state_type  next_tw_state;
    logic [3:0]    cnt;
    logic [3:0]    next_cnt;
    logic [7:0]    shift;
    logic [7:0]    next_shift;
    logic          sdo;
    logic          next_sdo;
    logic          sda_oe;
    logic          next_sda_oe;
    logic          reading;
    logic          next_reading;
    logic          ack_pending;
    logic          next_ack_pending;
    logic          busy_low;
    logic          next_busy_low;
    logic          tx_taken;
    logic          next_tx_taken;
    host_byte_type cmd;
    host_byte_type next_cmd;
    logic [7:0]    in_byte;
    logic          code_match;

    assign in_byte    = {shift[6:0], sdi};
    assign code_match = in_byte[`CODE_MATCH_MSB:0] == access_match_bits_in;

    always_comb begin
        next_spi_state   = spi_state;
        next_tw_state    = tw_state;
        next_cnt         = cnt;
        next_shift       = shift;
        next_sdo         = sdo;
        next_sda_oe      = sda_oe;
        next_reading     = reading;
        next_ack_pending = ack_pending;
        next_tx_taken    = 1'b0;
        next_cmd         = '{valid: 1'b0, data: cmd.data};
        next_busy_low    = ~device_busy_in;
        if (two_wire_mode_in) begin
            next_spi_state = SPI_IDLE;
            case (tw_state)
                TW_IDLE: begin
                end
                TW_ADDR, TW_WRITE: begin
                    if (sck_rise) begin
                        next_shift = in_byte;
                        next_cnt   = cnt + 4'h1;
                        if (cnt == `BYTE_LAST_BIT) begin
                            next_cnt = 4'h0;
                            if (tw_state == TW_WRITE) begin
                                next_cmd         = '{valid: 1'b1, data: in_byte};
                                next_ack_pending = 1'b1;
                            end else if (shift[6:0] == `TWO_WIRE_ADDR) begin
                                next_ack_pending = 1'b1;
                                next_reading     = sdi;
                            end else begin
                                next_tw_state = TW_IDLE;
                            end
                        end
                    end
                    if (sck_fall && ack_pending) begin
                        next_sda_oe      = 1'b1;
                        next_ack_pending = 1'b0;
                        next_tw_state    = TW_ACK;
                    end
                end
                TW_ACK, TW_RACK: begin
                    if (tw_state == TW_RACK && sck_rise && sdi) begin
                        next_tw_state = TW_IDLE;
                    end else if (sck_fall) begin
                        next_cnt = 4'h0;
                        if (reading) begin
                            next_sda_oe   = ~tx_byte_in[7];
                            next_shift    = {tx_byte_in[6:0], 1'b0};
                            next_tx_taken = 1'b1;
                            next_tw_state = TW_READ;
                        end else begin
                            next_sda_oe   = 1'b0;
                            next_tw_state = TW_WRITE;
                        end
                    end
                end
                TW_READ: begin
                    if (sck_rise) begin
                        next_cnt = cnt + 4'h1;
                    end
                    if (sck_fall) begin
                        if (cnt == `BYTE_BITS) begin
                            next_sda_oe   = 1'b0;
                            next_tw_state = TW_RACK;
                        end else begin
                            next_sda_oe = ~shift[7];
                            next_shift  = {shift[6:0], 1'b0};
                        end
                    end
                end
                default: next_tw_state = TW_IDLE;
            endcase
            if (tw_start) begin
                next_tw_state    = TW_ADDR;
                next_cnt         = 4'h0;
                next_ack_pending = 1'b0;
                next_sda_oe      = 1'b0;
            end else if (tw_stop) begin
                next_tw_state = TW_IDLE;
                next_sda_oe   = 1'b0;
            end
        end else begin
            next_tw_state = TW_IDLE;
            next_sda_oe   = 1'b0;
            if (!sel) begin
                next_spi_state = SPI_IDLE;
            end else begin
                case (spi_state)
                    SPI_IDLE: begin
                        next_spi_state = SPI_CODE;
                        next_cnt       = 4'h0;
                    end
                    SPI_CODE: begin
                        if (sck_rise) begin
                            next_shift = in_byte;
                            next_cnt   = cnt + 4'h1;
                            if (cnt == `BYTE_LAST_BIT) begin
                                next_cnt = 4'h0;
                                if (code_match && !device_busy_in) begin
                                    next_sdo       = 1'b0;
                                    next_reading   = in_byte[`CODE_DIR_BIT];
                                    next_spi_state = SPI_DATA;
                                    if (in_byte[`CODE_DIR_BIT]) begin
                                        next_shift    = tx_byte_in;
                                        next_tx_taken = 1'b1;
                                    end
                                end else begin
                                    next_sdo       = 1'b1;
                                    next_spi_state = SPI_REFUSE;
                                end
                            end
                        end
                    end
                    SPI_DATA: begin
                        if (reading && sck_fall) begin
                            next_sdo   = shift[7];
                            next_shift = {shift[6:0], 1'b0};
                            next_cnt   = cnt + 4'h1;
                            if (cnt == `BYTE_LAST_BIT) begin
                                next_cnt      = 4'h0;
                                next_shift    = tx_byte_in;
                                next_tx_taken = 1'b1;
                            end
                        end else if (!reading && sck_rise) begin
                            next_shift = in_byte;
                            next_cnt   = cnt + 4'h1;
                            if (cnt == `BYTE_LAST_BIT) begin
                                next_cnt = 4'h0;
                                next_cmd = '{valid: 1'b1, data: in_byte};
                            end
                        end
                    end
                    SPI_REFUSE: begin
                    end
                    default: next_spi_state = SPI_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            spi_state   <= SPI_IDLE;
            tw_state    <= TW_IDLE;
            cnt         <= 4'h0;
            shift       <= 8'h00;
            sdo         <= `SERIAL_OUT_RESET;
            sda_oe      <= 1'b0;
            reading     <= 1'b0;
            ack_pending <= 1'b0;
            busy_low    <= 1'b0;
            tx_taken    <= 1'b0;
            cmd         <= '{valid: 1'b0, data: 8'h00};
        end else begin
            spi_state   <= next_spi_state;
            tw_state    <= next_tw_state;
            cnt         <= next_cnt;
            shift       <= next_shift;
            sdo         <= next_sdo;
            sda_oe      <= next_sda_oe;
            reading     <= next_reading;
            ack_pending <= next_ack_pending;
            busy_low    <= next_busy_low;
            tx_taken    <= next_tx_taken;
            cmd         <= next_cmd;
        end
    end

    //==========================================================
    // Pin multiplexing
    assign host_serial_in_out     = 1'b0;
    assign host_serial_in_oe_out  = sda_oe;
    assign host_serial_out_out    = two_wire_mode_in ? gpio_out_in[0] : sdo;
    assign host_serial_out_oe_out = two_wire_mode_in ? gpio_oe_in[0]
                                  : (!tristate_mode_in || sel);
    assign gpio_pin_one_out       = gpio_out_in[1];
    assign gpio_pin_one_oe_out    = two_wire_mode_in & gpio_oe_in[1];
    assign busy_low_out           = two_wire_mode_in ? gpio_out_in[2] : busy_low;
    assign busy_low_oe_out        = two_wire_mode_in ? gpio_oe_in[2] : 1'b1;
    assign gpio_read_out          = {sync2[4], sync2[2], sync2[3]};
    assign tx_taken_out           = tx_taken;
    assign host_cmd_out           = cmd;
    assign link_status_out        = '{spi_active: spi_state == SPI_DATA,
                                      spi_refused: spi_state == SPI_REFUSE,
                                      reading: reading};

    //==========================================================
    // Checks
    logic code_done;
    assign code_done = !two_wire_mode_in && sel && spi_state == SPI_CODE && sck_rise
                       && cnt == `BYTE_LAST_BIT;

    property p_code_ack;
        @(posedge clk_in) disable iff (reset_in)
        code_done && code_match && !device_busy_in |=> sdo == 1'b0 && spi_state == SPI_DATA;
    endproperty
    a_code_ack: assert property (p_code_ack) else $error("code match not acknowledged");

    property p_code_nack;
        @(posedge clk_in) disable iff (reset_in)
        code_done && !code_match |=> sdo == 1'b1 && spi_state == SPI_REFUSE;
    endproperty
    a_code_nack: assert property (p_code_nack) else $error("bad code not refused");

    property p_direction;
        @(posedge clk_in) disable iff (reset_in)
        code_done && code_match && !device_busy_in
            |=> reading == $past(in_byte[`CODE_DIR_BIT]);
    endproperty
    a_direction: assert property (p_direction) else $error("direction bit lost");

    property p_addr_ack;
        @(posedge clk_in) disable iff (reset_in)
        two_wire_mode_in && tw_state == TW_ADDR && sck_rise && cnt == `BYTE_LAST_BIT
            && shift[6:0] == `TWO_WIRE_ADDR && !tw_start && !tw_stop |=> ack_pending;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

    property p_gpio_busy;
        @(posedge clk_in) disable iff (reset_in)
        two_wire_mode_in |-> busy_low_oe_out == gpio_oe_in[2] && !gpio_pin_one_out == !gpio_out_in[1];
    endproperty
    a_gpio_busy: assert property (p_gpio_busy) else $error("busy pin not freed");

    property p_busy;
        @(posedge clk_in) disable iff (reset_in)
        !two_wire_mode_in && device_busy_in ##1 !two_wire_mode_in |-> !busy_low_out;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not shown");

    property p_tristate;
        @(posedge clk_in) disable iff (reset_in)
        !two_wire_mode_in && tristate_mode_in && !sel |-> !host_serial_out_oe_out;
    endproperty
    a_tristate: assert property (p_tristate) else $error("output driven while idle");

    property p_deselect;
        @(posedge clk_in) disable iff (reset_in)
        !two_wire_mode_in && !sel |=> spi_state == SPI_IDLE && !cmd.valid;
    endproperty
    a_deselect: assert property (p_deselect) else $error("activity while deselected");

    property p_read_shift;
        @(posedge clk_in) disable iff (reset_in)
        !two_wire_mode_in && sel && spi_state == SPI_DATA && reading && sck_fall
            |=> sdo == $past(shift[7]);
    endproperty
    a_read_shift: assert property (p_read_shift) else $error("read bit order wrong");

    property p_cmd_byte;
        @(posedge clk_in) disable iff (reset_in)
        !two_wire_mode_in && sel && spi_state == SPI_DATA && !reading && sck_rise
            && cnt == `BYTE_LAST_BIT |=> cmd.valid && cmd.data == $past(in_byte) ##1 !cmd.valid;
    endproperty
    a_cmd_byte: assert property (p_cmd_byte) else $error("command byte lost");

endmodule

// ==== core/host_serial_slave_port_defs.svh ====
// Constants of the host serial slave port
//==========================================================
`ifndef HOST_SERIAL_SLAVE_PORT_DEFS_SVH
`define HOST_SERIAL_SLAVE_PORT_DEFS_SVH

//==========================================================
// Access code layout
`define CODE_MATCH_MSB   5
`define CODE_DIR_BIT     6
`define BYTE_LAST_BIT    4'h7
`define BYTE_BITS        4'h8

//==========================================================
// Two-wire slave address and reset values
`define TWO_WIRE_ADDR    7'h16
`define SERIAL_OUT_RESET 1'b1

`endif

// ==== core/host_serial_slave_port_pkg.sv ====
// Types of the host serial slave port
package host_serial_slave_port_pkg;

    typedef enum logic [3:0] {
        SPI_IDLE   = 4'h1,
        SPI_CODE   = 4'h2,
        SPI_DATA   = 4'h4,
        SPI_REFUSE = 4'h8
    } spi_state_type;

    typedef enum logic [5:0] {
        TW_IDLE  = 6'h01,
        TW_ADDR  = 6'h02,
        TW_WRITE = 6'h04,
        TW_ACK   = 6'h08,
        TW_READ  = 6'h10,
        TW_RACK  = 6'h20
    } tw_state_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } host_byte_type;

    typedef struct packed {
        logic spi_active;
        logic spi_refused;
        logic reading;
    } link_status_type;

endpackage

// ==== verif/host_master_model.sv ====
// Host microcontroller model: serial master and two-wire master
module host_master_model (
    output logic      clock_out,
    output logic      data_out,
    output logic      select_out,
    input  wire logic sdo_in,
    input  wire logic sda_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        clock_out  = 1'b0;
        data_out   = 1'b1;
        select_out = 1'b0;
    end

    //==========================================================
    // Serial link
    task automatic frame_on(input logic on);
        select_out = on;
        if (!on) begin
            data_out = ~data_out;
        end
        #300;
    endtask

    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            data_out = tx[i];
            #100 clock_out = 1'b1;
            #50 rx[i] = sdo_in;
            #50 clock_out = 1'b0;
        end
        #40 ack = sdo_in;
        #60;
    endtask

    //==========================================================
    // Two-wire master, data released as a high level
    task automatic tw_start();
        data_out  = 1'b1;
        clock_out = 1'b1;
        #200 data_out = 1'b0;
        #200 clock_out = 1'b0;
    endtask

    task automatic tw_byte(input logic [7:0] tx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #25 data_out = tx[i];
            #75 clock_out = 1'b1;
            #100 clock_out = 1'b0;
        end
        #25 data_out = 1'b1;
        #75 clock_out = 1'b1;
        #50 ack = ~sda_in;
        #50 clock_out = 1'b0;
    endtask

    task automatic tw_read(output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            #25 data_out = 1'b1;
            #75 clock_out = 1'b1;
            #50 rx[i] = sda_in;
            #50 clock_out = 1'b0;
        end
        #25 data_out = 1'b1;
        #75 clock_out = 1'b1;
        #100 clock_out = 1'b0;
    endtask

    task automatic tw_stop();
        #25 data_out = 1'b0;
        #75 clock_out = 1'b1;
        #100 data_out = 1'b1;
        #200;
    endtask
endmodule

// ==== verif/host_serial_slave_port_tb_top.sv ====
// Testbench of the host serial slave port
module host_serial_slave_port_tb_top
    import host_serial_slave_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic            clk_in, reset_in, two_wire_mode_in, tristate_mode_in, device_busy_in;
    logic [5:0]      match;
    logic [2:0]      gout, goe, gread;
    logic [7:0]      tx_byte;
    logic [31:0]     rnd;
    logic            sck, mosi, sel_host, sdi_o, sdi_oe, sdo_o, sdo_oe;
    logic            g1, g1_oe, busy_o, busy_oe, tx_taken;
    wire logic       sda_line, sdo_line, sel_line, busy_line;
    host_byte_type   cmd;
    link_status_type status;
    logic [7:0]      sent_q[$];
    logic [7:0]      exp_q[$];
    int              num_errors = 0;
    int              num_checks = 0;

    assign sda_line  = mosi & ~(sdi_oe & ~sdi_o);
    assign sdo_line  = sdo_oe ? sdo_o : 1'b0;
    assign sel_line  = g1_oe ? g1 : sel_host;
    assign busy_line = busy_oe ? busy_o : 1'b0;

    host_serial_slave_port i_dut (
        .clk_in(clk_in), .reset_in(reset_in), .host_shift_clock_in(sck),
        .host_serial_in_in(sda_line), .host_serial_in_out(sdi_o),
        .host_serial_in_oe_out(sdi_oe), .host_serial_out_out(sdo_o),
        .host_serial_out_oe_out(sdo_oe), .gpio_pin_zero_in(sdo_line),
        .host_select_in(sel_line), .gpio_pin_one_out(g1), .gpio_pin_one_oe_out(g1_oe),
        .busy_low_out(busy_o), .busy_low_oe_out(busy_oe), .gpio_pin_two_in(busy_line),
        .two_wire_mode_in(two_wire_mode_in), .tristate_mode_in(tristate_mode_in),
        .access_match_bits_in(match), .device_busy_in(device_busy_in),
        .gpio_out_in(gout), .gpio_oe_in(goe), .gpio_read_out(gread),
        .tx_byte_in(tx_byte), .tx_taken_out(tx_taken), .host_cmd_out(cmd),
        .link_status_out(status)
    );

    host_master_model host (
        .clock_out(sck), .data_out(mosi), .select_out(sel_host),
        .sdo_in(sdo_line), .sda_in(sda_line)
    );

    //==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic spi_frame(input logic [7:0] code, input int n, input logic ack_exp);
        logic [7:0] tx, rx;
        logic       ack;
        sent_q.delete();
        host.frame_on(1'b1);
        host.shift_byte(code, rx, ack);
        check_byte("ack", {7'h0, ~ack_exp}, {7'h0, ack});
        for (int k = 0; k < n; k++) begin
            rnd = lfsr(rnd);
            tx = rnd[7:0];
            if (ack_exp && !code[6]) begin
                exp_q.push_back(tx);
            end
            host.shift_byte(tx, rx, ack);
            check_byte("rx", !ack_exp ? 8'hff : (code[6] ? sent_q.pop_front() : 8'h00), rx);
        end
        check_byte("sdo_oe_on", 8'h01, {7'h0, sdo_oe});
        host.frame_on(1'b0);
        check_byte("sdo_oe_off", {7'h0, ~tristate_mode_in}, {7'h0, sdo_oe});
        check_byte("cmd_left", 8'h00, 8'(exp_q.size()));
    endtask

    //==========================================================
    // Clock, read data source and command monitor
    always #12.5 clk_in = ~clk_in;

    always @(negedge clk_in) begin
        if (tx_taken === 1'b1) begin
            sent_q.push_back(tx_byte);
            rnd = lfsr(rnd);
            tx_byte <= rnd[7:0];
        end
    end

    always @(negedge clk_in) begin
        if (cmd.valid === 1'b1) begin
            check_byte("cmd", exp_q.size() ? exp_q.pop_front() : 8'hxx, cmd.data);
        end
    end

    initial begin
        #500000;
        num_errors++;
        test_done();
    end

    //==========================================================
    // Main sequence
    initial begin
        logic [7:0] code, rx;
        logic       ack, b;
        clk_in = 1'b0;
        reset_in = 1'b1;
        {two_wire_mode_in, tristate_mode_in, device_busy_in} = 3'h0;
        {gout, goe} = 6'h00;
        rnd = 32'h6f45;
        match = rnd[5:0];
        tx_byte = rnd[15:8];
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'b0;
        check_byte("reset_pins", 8'h02, {6'h0, sdo_o, sdi_oe});
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_in);
            rnd = lfsr(rnd);
            b = rnd[0];
            device_busy_in = b;
            @(negedge clk_in);
            check_byte("busy_low", {6'h0, busy_oe, ~b}, {6'h0, busy_oe, busy_o});
        end
        for (int s = 0; s < 6; s++) begin
            @(negedge clk_in);
            tristate_mode_in = s[0];
            device_busy_in = (s == 5);
            rnd = lfsr(rnd);
            match = rnd[5:0];
            code = {rnd[7], s[1], (s == 4) ? ~rnd[5:0] : rnd[5:0]};
            spi_frame(code, 3, s < 4);
        end
        device_busy_in = 1'b0;
        host.shift_byte({2'b00, match}, rx, ack);
        host.shift_byte(8'h5a, rx, ack);
        check_byte("unselected_rx", 8'h00, rx);
        @(negedge clk_in);
        two_wire_mode_in = 1'b1;
        for (int a = 0; a < 2; a++) begin
            host.tw_start();
            host.tw_byte({(a == 0) ? 7'h16 : 7'h15, 1'b0}, ack);
            check_byte("tw_addr_ack", {7'h0, a == 0}, {7'h0, ack});
            rnd = lfsr(rnd);
            if (a == 0) begin
                exp_q.push_back(rnd[7:0]);
            end
            host.tw_byte(rnd[7:0], ack);
            check_byte("tw_data_ack", {7'h0, a == 0}, {7'h0, ack});
            host.tw_stop();
        end
        sent_q.delete();
        host.tw_start();
        host.tw_byte({7'h16, 1'b1}, ack);
        check_byte("tw_raddr_ack", 8'h01, {7'h0, ack});
        host.tw_read(rx);
        check_byte("tw_rx", sent_q.size() ? sent_q.pop_front() : 8'hxx, rx);
        host.tw_stop();
        check_byte("cmd_left", 8'h00, 8'(exp_q.size()));
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_in);
            rnd = lfsr(rnd);
            gout = rnd[2:0];
            goe = rnd[5:3];
            repeat (4) @(negedge clk_in);
            check_byte("gpio_pins", {2'b0, goe, gout},
                       {2'b0, busy_oe, g1_oe, sdo_oe, busy_o, g1, sdo_o});
            check_byte("gpio_read", {5'h0, goe & gout}, {5'h0, gread});
        end
        test_done();
    end
endmodule
